// File: core/osc_tick_gen.sv
// fractional divider giving one enable pulse per watchdog oscillator cycle
`timescale 1ns/100ps
`default_nettype none
module osc_tick_gen
  import wdt_pkg::*;
#(
  parameter int OSC_KHZ = OSC_KHZ_DEF
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_b,
  output logic      o_tick
);
  localparam logic [17:0] STEP = 18'(OSC_KHZ);
  localparam logic [17:0] WRAP = 18'(SYS_CLK_KHZ);

  logic [17:0] acc_r;
  logic [17:0] acc_sum;
  logic        wrap_hit;

  // phase accumulator: 125 MHz is no integer multiple of 128 kHz, so jitter of one cycle is traded for exact rate
  assign acc_sum  = acc_r + STEP;
  assign wrap_hit = (acc_sum >= WRAP);
  assign o_tick   = wrap_hit;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      acc_r <= 18'h00000;
    end else if (wrap_hit) begin
      acc_r <= acc_sum - WRAP;
    end else begin
      acc_r <= acc_sum;
    end
  end
endmodule : osc_tick_gen
`default_nettype wire

// File: core/timeout_counter.sv
// tick counter with prescale-selected expiry point
`timescale 1ns/100ps
`default_nettype none
module timeout_counter
  import wdt_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_run,
  input  wire logic       i_tick,
  input  wire logic       i_restart,
  input  wire logic [3:0] i_prescale,
  output logic            o_expire
);
  logic [19:0] cnt_r;
  logic [19:0] cnt_nxt;
  logic [3:0]  ps_eff;
  logic [20:0] limit;
  logic [19:0] last_cnt;

  // reserved codes behave as the longest period, never shorter than asked
  assign ps_eff   = (i_prescale > PS_MAX) ? PS_MAX : i_prescale;
  assign limit    = 21'(BASE_TICKS) << ps_eff;
  assign last_cnt = 20'(limit - 21'h000001);
  assign o_expire = i_run & i_tick & (cnt_r == last_cnt);

  // restart, stop and expiry all start a fresh period
  assign cnt_nxt = (i_restart | ~i_run | o_expire) ? 20'h00000 :
                   (i_tick ? cnt_r + 20'h00001 : cnt_r);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      cnt_r <= 20'h00000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : timeout_counter
`default_nettype wire

// File: core/watchdog_timer_unit.sv
// watchdog timer unit: AHB-Lite registers, mode control, change window and time-out actions
`timescale 1ns/100ps
`default_nettype none
module watchdog_timer_unit
  import wdt_pkg::*;
#(
  parameter int OSC_KHZ = OSC_KHZ_DEF
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_always_on_fuse,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic             o_timeout_irq,
  output logic             o_dog_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // bus address phase
  ////////////////////////////////////////////////////////////////////////////

  logic        dph_wr_r;
  logic [7:0]  dph_addr_r;
  logic        ahb_take;
  logic        ahb_wr_take;
  logic        ahb_rd_take;

  // only whole-word nonseq/seq writes are taken, other write sizes are ignored; nonseq/seq reads of any size are taken
  assign ahb_take    = i_hsel & i_htrans[1] & i_hready;
  assign ahb_wr_take = ahb_take & i_hwrite & (i_hsize == HSIZE_WORD);
  assign ahb_rd_take = ahb_take & ~i_hwrite;

  // latch the address phase for the write data phase that follows
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      dph_wr_r   <= 1'b0;
      dph_addr_r <= 8'h00;
    end else begin
      dph_wr_r   <= ahb_wr_take;
      dph_addr_r <= i_haddr[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write decode in the data phase
  ////////////////////////////////////////////////////////////////////////////

  logic [7:0]  wd;
  logic        wr_csr;
  logic        wr_cause;
  logic        wr_restart;
  logic        vec_ack;

  assign wd         = i_hwdata[7:0];
  assign wr_csr     = dph_wr_r & (dph_addr_r == CSR_OFS);
  assign wr_cause   = dph_wr_r & (dph_addr_r == CAUSE_OFS);
  assign wr_restart = dph_wr_r & (dph_addr_r == RESTART_OFS);
  assign vec_ack    = dph_wr_r & (dph_addr_r == VECTOR_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // control state and mode
  ////////////////////////////////////////////////////////////////////////////

  logic        flag_r;
  logic        ie_r;
  logic        re_r;
  logic        ce_r;
  logic [2:0]  win_cnt_r;
  logic [3:0]  ps_r;
  logic        dog_cause_r;
  logic        re_eff;
  logic        ie_eff;
  wdt_mode_t   mode;

  // fuse and reset-cause override the stored reset-enable; fuse masks the interrupt
  assign re_eff = re_r | i_always_on_fuse | dog_cause_r;
  assign ie_eff = ie_r & ~i_always_on_fuse;
  assign mode   = wdt_mode_t'({re_eff, ie_eff});

  ////////////////////////////////////////////////////////////////////////////
  // oscillator tick and counter
  ////////////////////////////////////////////////////////////////////////////

  logic        osc_tick;
  logic        wdt_expire;
  logic        cnt_run;

  assign cnt_run = (mode != MODE_STOP);

  osc_tick_gen #(
    .OSC_KHZ (OSC_KHZ)
  ) i_osc_tick_gen (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .o_tick    (osc_tick)
  );

  timeout_counter i_timeout_counter (
    .i_sys_clk  (i_sys_clk),
    .i_rst_b    (i_rst_b),
    .i_run      (cnt_run),
    .i_tick     (osc_tick),
    .i_restart  (wr_restart),
    .i_prescale (ps_r),
    .o_expire   (wdt_expire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // expiry action per mode
  ////////////////////////////////////////////////////////////////////////////

  logic        irq_evt;
  logic        rst_evt;

  // combined mode escalates to reset only when the previous interrupt went unserviced
  always_comb begin
    irq_evt = 1'b0;
    rst_evt = 1'b0;
    unique case (mode)
      MODE_STOP: begin
        irq_evt = 1'b0;
      end
      MODE_IRQ: begin
        irq_evt = wdt_expire;
      end
      MODE_RST: begin
        rst_evt = wdt_expire;
      end
      MODE_BOTH: begin
        irq_evt = wdt_expire & ~flag_r;
        rst_evt = wdt_expire & flag_r;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // timed change sequence
  ////////////////////////////////////////////////////////////////////////////

  logic        open_seq;
  logic        chg_wr;
  logic        ce_nxt;
  logic [2:0]  win_cnt_nxt;

  // opening write needs change-enable and reset-enable together
  assign open_seq = wr_csr & wd[CE_BIT] & wd[RE_BIT];
  // one change write is accepted while the window is open, then it closes
  assign chg_wr   = wr_csr & ce_r & ~wd[CE_BIT];

  assign ce_nxt      = open_seq | (ce_r & ~chg_wr & (win_cnt_r != 3'h1) & ~rst_evt);
  assign win_cnt_nxt = open_seq ? CHG_WIN_CYC : (ce_r ? win_cnt_r - 3'h1 : 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  // next values of the control/status fields
  ////////////////////////////////////////////////////////////////////////////

  logic        flag_clr;
  logic        flag_nxt;
  logic        ie_nxt;
  logic        re_nxt;
  logic [3:0]  ps_nxt;
  logic        cause_nxt;
  logic        irq_nxt;

  // write-one or the vector clears the flag; a time-out in the same cycle wins
  assign flag_clr  = (wr_csr & wd[FLAG_BIT]) | vec_ack;
  assign flag_nxt  = irq_evt | (flag_r & ~flag_clr & ~rst_evt);

  // vector in combined mode drops back to plain reset mode
  assign ie_nxt    = rst_evt                ? 1'b0 :
                     (vec_ack & re_eff)     ? 1'b0 :
                     wr_csr                 ? wd[IE_BIT] : ie_r;

  // setting reset-enable is free; clearing it needs the window
  assign re_nxt    = (wr_csr & wd[RE_BIT]) ? 1'b1 :
                     (chg_wr & ~dog_cause_r) ? 1'b0 : re_r;

  // prescale moves only inside the window; a watchdog reset restores the default
  assign ps_nxt    = rst_evt ? PS_RST :
                     (chg_wr ? {wd[PS3_BIT], wd[2:0]} : ps_r);

  // cause flag survives until software writes zero; a new reset wins
  assign cause_nxt = rst_evt | (dog_cause_r & ~(wr_cause & ~wd[CAUSE_BIT]));

  assign irq_nxt   = flag_nxt & ie_nxt & ~i_always_on_fuse;

  // field registers; the stored reset-enable comes up as zero
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      flag_r      <= CSR_RST[FLAG_BIT];
      ie_r        <= CSR_RST[IE_BIT];
      re_r        <= RE_RST;
      ce_r        <= CSR_RST[CE_BIT];
      win_cnt_r   <= 3'h0;
      ps_r        <= PS_RST;
      dog_cause_r <= 1'b0;
    end else begin
      flag_r      <= flag_nxt;
      ie_r        <= ie_nxt;
      re_r        <= re_nxt;
      ce_r        <= ce_nxt;
      win_cnt_r   <= win_cnt_nxt;
      ps_r        <= ps_nxt;
      dog_cause_r <= cause_nxt;
    end
  end

  // interrupt level runs without the cpu clock gate, so it can wake a sleeping core
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_timeout_irq <= 1'b0;
      o_dog_reset   <= 1'b0;
    end else begin
      o_timeout_irq <= irq_nxt;
      o_dog_reset   <= rst_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  ////////////////////////////////////////////////////////////////////////////

  logic [7:0]  csr_view;
  logic [7:0]  cause_view;
  logic [31:0] rd_mux;

  // reads show effective enables so software sees what the fuse forces
  assign csr_view   = {flag_r, ie_eff, ps_r[3], ce_r, re_eff, ps_r[2:0]};
  assign cause_view = 8'(dog_cause_r) << CAUSE_BIT;
  assign rd_mux     = (i_haddr[7:0] == CSR_OFS)   ? {24'h000000, csr_view} :
                      (i_haddr[7:0] == CAUSE_OFS) ? {24'h000000, cause_view} : 32'h00000000;

  // read data is staged at the address edge: zero wait states, but a read right after a
  // write to the same register returns the value before that write
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_hrdata    <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hrdata    <= ahb_rd_take ? rd_mux : 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  ce_window_len_a: assert property (ce_r[*4] |=> !ce_r)
    else $error("change enable held beyond four cycles");

  ce_opens_a: assert property (open_seq |=> ce_r && win_cnt_r == 3'h4)
    else $error("opening write did not open the change window");

  fuse_forces_a: assert property (
    i_always_on_fuse |-> mode == MODE_RST && csr_view[RE_BIT] && !csr_view[IE_BIT])
    else $error("fuse did not force reset-only mode");

  irq_raise_a: assert property (irq_evt && !wr_csr && !i_always_on_fuse |=> flag_r && o_timeout_irq)
    else $error("time-out did not raise flag and interrupt");

  reset_mode_a: assert property (wdt_expire && mode == MODE_RST |=> o_dog_reset && dog_cause_r ##1 !o_dog_reset)
    else $error("reset mode expiry gave no single-cycle reset");

  both_first_a: assert property (wdt_expire && mode == MODE_BOTH && !flag_r |=> !o_dog_reset && flag_r)
    else $error("combined mode first expiry did not interrupt");

  vector_clear_a: assert property (vec_ack && mode == MODE_BOTH && !wdt_expire |=> !ie_r && !flag_r)
    else $error("vector did not leave combined mode");

  stopped_a: assert property (mode == MODE_STOP |-> !wdt_expire && !$past(rst_evt))
    else $error("stopped watchdog acted on expiry");

  window_guard_a: assert property (
    wr_csr && !ce_r && !rst_evt |=> ps_r == $past(ps_r) && (re_r || !$past(re_r)))
    else $error("protected field changed outside window");

  stay_enabled_a: assert property (rst_evt |=> re_eff ##1 re_eff)
    else $error("watchdog disabled after its own reset");

  restart_a: assert property (wr_restart && cnt_run |=> !wdt_expire)
    else $error("expiry right after restart");

  irq_seen_c: cover property (irq_evt ##[1:20] vec_ack);
  escalate_c: cover property (mode == MODE_BOTH && rst_evt);
  change_c:   cover property (open_seq ##[1:3] chg_wr);
  reset_c:    cover property (o_dog_reset);
endmodule : watchdog_timer_unit
`default_nettype wire

// File: pkg/wdt_pkg.sv
// constants, field layout and mode type shared by the watchdog timer unit
// Operation
// - Counter advances on ticks of a dedicated 128 kHz oscillator, not the system clock; the ticks here come from a fractional divider on the system clock.
// - At the time-out count the watchdog interrupts, resets, or both, per mode.
// - A restart clears the counter; software must restart before the time-out.
// - Interrupt-only mode raises an interrupt on expiry, able to wake from sleep.
// - Reset-only mode asserts a system reset on expiry.
// - Combined mode: first expiry interrupts, a later unserviced expiry resets.
// - Programmed always-on fuse forces reset-only mode: reset-enable 1, interrupt-enable 0.
// - Within four cycles one write with change-enable zero updates reset-enable and prescale.
// - Selectable time-out spans 16 ms to 8 s.
// - After a watchdog reset the watchdog stays enabled.
// - Control register layout: flag7, ie6, ps3 at 5, ce4, re3, ps2..0; reset zero.
// - Time-out with interrupts enabled sets the flag; vector or write-one clears it.
// - In combined mode the vector clears interrupt-enable and flag, leaving reset mode.
// - Change-enable clears itself four clock cycles after being written one.
// - Prescale 0..9 selects 2048 doubling to 1048576 ticks; codes 10..15 reserved.
package wdt_pkg;
  // register byte offsets
  localparam logic [7:0]  CSR_OFS       = 8'h00;
  localparam logic [7:0]  CAUSE_OFS     = 8'h04;
  localparam logic [7:0]  RESTART_OFS   = 8'h08;
  localparam logic [7:0]  VECTOR_OFS    = 8'h0C;
  // control/status field positions
  localparam int          FLAG_BIT      = 7;
  localparam int          IE_BIT        = 6;
  localparam int          PS3_BIT       = 5;
  localparam int          CE_BIT        = 4;
  localparam int          RE_BIT        = 3;
  localparam int          CAUSE_BIT     = 3;
  // reset values
  localparam logic [7:0]  CSR_RST       = 8'h00;
  localparam logic        RE_RST        = 1'b0;
  localparam logic [3:0]  PS_RST        = 4'h0;
  // timing
  localparam int          SYS_CLK_KHZ   = 125000;
  localparam int          OSC_KHZ_DEF   = 128;
  localparam logic [2:0]  CHG_WIN_CYC   = 3'h4;
  localparam int          BASE_TICKS    = 2048;
  localparam logic [3:0]  PS_MAX        = 4'h9;
  localparam int          TOUT_MIN_MS   = 16;
  localparam int          TOUT_MAX_MS   = 8000;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;

  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_IRQ  = 2'b01,
    MODE_RST  = 2'b10,
    MODE_BOTH = 2'b11
  } wdt_mode_t;
endpackage : wdt_pkg

// File: verification/watchdog_timer_unit_bench.sv
// self-checking bench for the watchdog timer unit, registers reached over ahb-lite
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module watchdog_timer_unit_bench
  import wdt_pkg::*;
;
  // one osc tick per clock keeps the shortest time-out at 2048 clocks
  localparam int TICK_KHZ = 125000;
  localparam int SLACK    = 12;

  logic        sys_clk;
  logic        rst_b;
  logic        fuse;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  wire         hready;
  logic        hresp;
  logic        irq;
  logic        dog_rst;
  int          fail_count;
  int          cmp_count;
  int          n;
  logic [31:0] rv;

  watchdog_timer_unit #(.OSC_KHZ(TICK_KHZ)) i_watchdog_timer_unit (
    .i_sys_clk        (sys_clk),
    .i_rst_b          (rst_b),
    .i_always_on_fuse (fuse),
    .i_hsel           (hsel),
    .i_haddr          (haddr),
    .i_htrans         (htrans),
    .i_hwrite         (hwrite),
    .i_hsize          (hsize),
    .i_hwdata         (hwdata),
    .i_hready         (hready),
    .o_hrdata         (hrdata),
    .o_hreadyout      (hready),
    .o_hresp          (hresp),
    .o_timeout_irq    (irq),
    .o_dog_reset      (dog_rst)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock, verdict and watchdog
  always #4 sys_clk = ~sys_clk;

  task automatic complete_run();
    if (fail_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // about 30k cycles of tests expected, so twice that means a hang
  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus and wait helpers
  task automatic do_reset(input logic f);
    rst_b <= 1'b0;
    fuse  <= f;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
  endtask : do_reset

  // single word transfer; read data is taken at the edge that ends the data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= HSIZE_WORD;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    r = hrdata;
    `CHK(hresp, 1'b0)
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h00000000, r);
  endtask : rd

  // counts clocks until the chosen output is high, giving up at lim
  task automatic wait_ev(input bit sel, input int lim, output int cnt);
    cnt = 0;
    while (cnt < lim && (sel ? dog_rst : irq) !== 1'b1) begin
      @(posedge sys_clk);
      cnt++;
    end
  endtask : wait_ev

  task automatic chk_period(input int cnt, input int ticks);
    `CHK(cnt >= ticks - SLACK && cnt <= ticks + SLACK, 1'b1)
  endtask : chk_period

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_values();
    rd(CSR_OFS, rv);
    `CHK(rv, {24'h000000, CSR_RST})
    rd(CAUSE_OFS, rv);
    `CHK(rv, 32'h00000000)
    rd(8'h10, rv);
    `CHK(rv, 32'h00000000)
  endtask : t_reset_values

  task automatic t_change_window();
    wr(CSR_OFS, 32'h00000018);
    wr(CSR_OFS, 32'h00000001);
    rd(CSR_OFS, rv);
    `CHK(rv, 32'h00000001)
    wr(CSR_OFS, 32'h00000002);
    rd(CSR_OFS, rv);
    `CHK(rv, 32'h00000001)
    wr(CSR_OFS, 32'h00000009);
    rd(CSR_OFS, rv);
    `CHK(rv, 32'h00000009)
    // window lapses after four clocks, so a late write cannot clear re
    wr(CSR_OFS, 32'h00000018);
    repeat (6) @(posedge sys_clk);
    wr(CSR_OFS, 32'h00000000);
    rd(CSR_OFS, rv);
    `CHK(rv, 32'h00000009)
    wr(CSR_OFS, 32'h00000018);
    wr(CSR_OFS, 32'h00000000);
    rd(CSR_OFS, rv);
    `CHK(rv, 32'h00000000)
  endtask : t_change_window

  task automatic t_irq_mode();
    wr(CSR_OFS, 32'h00000040);
    wr(RESTART_OFS, 32'h00000000);
    wait_ev(1'b0, 5000, n);
    chk_period(n, BASE_TICKS);
    `CHK(dog_rst, 1'b0)
    rd(CSR_OFS, rv);
    `CHK(rv, 32'h000000C0)
    wr(CSR_OFS, 32'h000000C0);
    rd(CSR_OFS, rv);
    `CHK(rv, 32'h00000040)
    `CHK(irq, 1'b0)
    // code one doubles the period; restart first so a shorter period cannot fire at once
    wr(RESTART_OFS, 32'h00000000);
    wr(CSR_OFS, 32'h00000018);
    wr(CSR_OFS, 32'h00000041);
    wr(RESTART_OFS, 32'h00000000);
    wait_ev(1'b0, 9000, n);
    chk_period(n, 2 * BASE_TICKS);
    wr(VECTOR_OFS, 32'h00000000);
    rd(CSR_OFS, rv);
    `CHK(rv, 32'h00000041)
    wr(CSR_OFS, 32'h00000018);
    wr(CSR_OFS, 32'h00000000);
  endtask : t_irq_mode

  task automatic t_combined();
    wr(CSR_OFS, 32'h00000018);
    wr(CSR_OFS, 32'h00000048);
    wr(RESTART_OFS, 32'h00000000);
    wait_ev(1'b0, 5000, n);
    chk_period(n, BASE_TICKS);
    wait_ev(1'b1, 5000, n);
    chk_period(n, BASE_TICKS);
    rd(CAUSE_OFS, rv);
    `CHK(rv[CAUSE_BIT], 1'b1)
    rd(CSR_OFS, rv);
    `CHK(rv, 32'h00000008)
    wait_ev(1'b1, 5000, n);
    chk_period(n, BASE_TICKS);
    // serviced vector drops to reset-only mode
    wr(CAUSE_OFS, 32'h00000000);
    wr(CSR_OFS, 32'h00000048);
    wr(RESTART_OFS, 32'h00000000);
    wait_ev(1'b0, 5000, n);
    wr(VECTOR_OFS, 32'h00000000);
    rd(CSR_OFS, rv);
    `CHK(rv, 32'h00000008)
    wait_ev(1'b1, 5000, n);
    `CHK(n < 5000, 1'b1)
    wr(CSR_OFS, 32'h00000018);
    wr(CSR_OFS, 32'h00000000);
    rd(CSR_OFS, rv);
    `CHK(rv, 32'h00000008)
  endtask : t_combined

  task automatic t_restart_and_stop();
    wr(RESTART_OFS, 32'h00000000);
    repeat (3) begin
      wait_ev(1'b1, 1500, n);
      `CHK(n, 1500)
      wr(RESTART_OFS, 32'h00000000);
    end
    wait_ev(1'b1, 5000, n);
    `CHK(n < 5000, 1'b1)
    // init-style shutdown: cause first, then re through the window
    wr(CAUSE_OFS, 32'h00000000);
    wr(CSR_OFS, 32'h00000018);
    wr(CSR_OFS, 32'h00000000);
    rd(CSR_OFS, rv);
    `CHK(rv, 32'h00000000)
    wait_ev(1'b1, 3000, n);
    `CHK(n, 3000)
    `CHK(irq, 1'b0)
  endtask : t_restart_and_stop

  task automatic t_fuse();
    do_reset(1'b1);
    rd(CSR_OFS, rv);
    `CHK(rv, 32'h00000008)
    wr(CSR_OFS, 32'h00000040);
    rd(CSR_OFS, rv);
    `CHK(rv, 32'h00000008)
    wr(RESTART_OFS, 32'h00000000);
    wait_ev(1'b1, 5000, n);
    chk_period(n, BASE_TICKS);
    `CHK(irq, 1'b0)
  endtask : t_fuse

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    sys_clk    = 1'b0;
    rst_b      = 1'b0;
    fuse       = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h00000000;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hsize      = HSIZE_WORD;
    hwdata     = 32'h00000000;
    fail_count = 0;
    cmp_count  = 0;
    do_reset(1'b0);
    t_reset_values();
    t_change_window();
    t_irq_mode();
    t_combined();
    t_restart_and_stop();
    t_fuse();
    complete_run();
  end
endmodule : watchdog_timer_unit_bench
`default_nettype wire
